// [common/lpx_pkg.sv]
// Shared constants, carriers and state types of the link packet exchange block.
// Assumes a 32-bit core word and a 16-bit link port that may run 8 bits wide.
package lpx_pkg;
  localparam int WORD_W        = 32;
  localparam int PORT_W        = 16;
  localparam int TAG_W         = 3;
  localparam int REPLAY_AW     = 6;
  localparam int RX_FIFO_DEPTH = 32;
  localparam logic [2:0] MAX_OUTSTANDING = 3'h7;
  localparam logic [2:0] BEATS_WIDE      = 3'h2;
  localparam logic [2:0] BEATS_NARROW    = 3'h4;
  // Physical fields in the upper half of a packet's first word.
  localparam int PKT_TAG_HI = 30;
  localparam int PKT_TAG_LO = 28;
  localparam int PKT_RSV_HI = 27;
  localparam int PKT_RSV_LO = 25;
  // Fields of a 16-bit control symbol.
  localparam int SYM_STYPE_HI = 15;
  localparam int SYM_STYPE_LO = 13;
  localparam int SYM_TAG_HI   = 12;
  localparam int SYM_TAG_LO   = 10;
  localparam logic [2:0] STYPE_ACCEPTED = 3'h0;
  localparam logic [2:0] STYPE_RETRY    = 3'h1;
  localparam logic [2:0] STYPE_NOT_ACC  = 3'h2;
  localparam logic [2:0] STYPE_RESTART  = 3'h3;
  localparam logic [3:0] BUF_STATUS_RETRY = 4'hF;
  localparam logic [5:0] SYM_RSV_ZERO     = 6'h00;
  localparam logic       TYPE_PACKET      = 1'h0;
  localparam logic       TYPE_SYMBOL      = 1'h1;

  typedef struct packed {
    logic              start;
    logic              ctl;
    logic [WORD_W-1:0] data;
  } lpx_item_s;

  typedef enum logic [1:0] {LPX_RX_IDLE, LPX_RX_PASS, LPX_RX_DISCARD} lpx_rx_e;

  typedef struct packed {
    lpx_rx_e              rxMode;
    logic [TAG_W-1:0]     expTag;
    logic [TAG_W-1:0]     sendTag;
    logic [TAG_W-1:0]     ackTag;
    logic [2:0]           outCnt;
    logic [REPLAY_AW-1:0] wrPtr;
    logic [REPLAY_AW-1:0] rdPtr;
    logic [REPLAY_AW-1:0] ackBase;
    logic                 replay;
    logic                 inPkt;
    logic                 busy;
    logic                 hsReq;
    logic                 symPend;
    logic [15:0]          sym;
    lpx_item_s            hsItem;
    logic                 ack1;
    logic                 ack2;
    logic                 txReady;
    logic                 rxValid;
    logic                 rxStart;
    logic                 symError;
    logic [WORD_W-1:0]    rxData;
  } lpx_core_s;

  typedef struct packed {
    logic              rst1, rst2, nar1, nar2, req1, req2, reqSeen;
    logic              tCtl, tStart, tFirst;
    logic [WORD_W-1:0] tShift;
    logic [2:0]        tLeft;
    logic [PORT_W-1:0] txData;
    logic              txValid, txFrame, txCtl;
    logic [PORT_W-1:0] rd1, rd2;
    logic              rv1, rv2, rf1, rf2, rc1, rc2;
    logic [WORD_W-1:0] rShift;
    logic [2:0]        rCnt;
    logic              rStart;
  } lpx_link_s;
endpackage

// [design/lpx_link_exchange.sv]
// Packet/acknowledge exchange for one port of a full-duplex parallel link.
// Assumes the partner keeps its own tag order and answers with control symbols.
`timescale 1ns/10ps

module lpx_async_fifo #(
  parameter int W     = 34,
  parameter int DEPTH = 32
) (
  // Write side
  input  wire logic         wrClk,
  input  wire logic         wrRstn,
  input  wire logic         wrValid,
  input  wire logic [W-1:0] wrData,
  output logic              wrReady,
  // Read side
  input  wire logic         rdClk,
  input  wire logic         rdRstn,
  output logic              rdValid,
  output logic [W-1:0]      rdData,
  input  wire logic         rdReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] bin, gray, sync1, sync2;
  } lpx_fside_s;
  lpx_fside_s w_reg, w_next, r_reg, r_next;
  logic [W-1:0] mem [DEPTH];

  // Gray pointers keep the crossing single-bit per step.
  assign wrReady = w_reg.gray != {~w_reg.sync2[AW:AW-1], w_reg.sync2[AW-2:0]};
  assign rdValid = r_reg.gray != r_reg.sync2;
  assign rdData  = mem[r_reg.bin[AW-1:0]];

  always_comb
  begin
    w_next       = w_reg;
    w_next.sync1 = r_reg.gray;
    w_next.sync2 = w_reg.sync1;
    if (wrValid && wrReady)
    begin
      w_next.bin  = w_reg.bin + 1'b1;
      w_next.gray = w_next.bin ^ (w_next.bin >> 1);
    end
    r_next       = r_reg;
    r_next.sync1 = w_reg.gray;
    r_next.sync2 = r_reg.sync1;
    if (rdValid && rdReady)
    begin
      r_next.bin  = r_reg.bin + 1'b1;
      r_next.gray = r_next.bin ^ (r_next.bin >> 1);
    end
  end

  always_ff @(posedge wrClk)
  begin
    w_reg <= wrRstn ? w_next : '0;
    if (wrValid && wrReady)
      mem[w_reg.bin[AW-1:0]] <= wrData;
  end

  always_ff @(posedge rdClk)
    r_reg <= rdRstn ? r_next : '0;
endmodule // lpx_async_fifo

module lpx_link_exchange (
  // Core clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Link clock and width strap
  input  wire logic        linkClk,
  input  wire logic        narrowMode,
  // Transmit packets from the core
  input  wire logic        txValid,
  input  wire logic [31:0] txData,
  input  wire logic        txStart,
  input  wire logic        txLast,
  input  wire logic        txHalf,
  output logic             txReady,
  // Received packets to the core
  output logic             rxValid,
  output logic [31:0]      rxData,
  output logic             rxStart,
  input  wire logic        rxReady,
  // Status
  output logic [2:0]       outstanding,
  output logic             symError,
  // Link transmit pins
  output logic [15:0]      lnkTxData,
  output logic             lnkTxValid,
  output logic             lnkTxFrame,
  output logic             lnkTxCtl,
  // Link receive pins
  input  wire logic [15:0] lnkRxData,
  input  wire logic        lnkRxValid,
  input  wire logic        lnkRxFrame,
  input  wire logic        lnkRxCtl
);
  lpx_pkg::lpx_core_s s, n;
  lpx_pkg::lpx_link_s l, ln;
  lpx_pkg::lpx_item_s pushItem, popItem, issueItem;
  logic        pushValid, pushReady, popValid, popReady, memWe, tsWe, accept;
  logic [32:0] replayMem [2**lpx_pkg::REPLAY_AW];
  logic [lpx_pkg::REPLAY_AW-1:0] tagStart [8];
  logic [32:0] memWd;
  logic [2:0]  stype, symTag, beats, nextCnt;
  logic        doSym;

  lpx_async_fifo #(.W(34), .DEPTH(lpx_pkg::RX_FIFO_DEPTH)) u_rxFifo (
    .wrClk(linkClk), .wrRstn(l.rst2), .wrValid(pushValid), .wrData(pushItem),
    .wrReady(pushReady), .rdClk(mclk), .rdRstn(rstn), .rdValid(popValid),
    .rdData(popItem), .rdReady(popReady));

  assign accept      = txValid && s.txReady;
  assign popReady    = !s.symPend;
  assign txReady     = s.txReady;
  assign rxValid     = s.rxValid;
  assign rxData      = s.rxData;
  assign rxStart     = s.rxStart;
  assign outstanding = s.outCnt;
  assign symError    = s.symError;
  assign lnkTxData   = l.txData;
  assign lnkTxValid  = l.txValid;
  assign lnkTxFrame  = l.txFrame;
  assign lnkTxCtl    = l.txCtl;

  // Core domain: receive checking, acknowledges, tagging and replay.
  always_comb
  begin
    n = s;
    n.rxValid  = 1'b0;
    n.rxStart  = 1'b0;
    n.symError = 1'b0;
    n.ack1     = l.reqSeen;
    n.ack2     = s.ack1;
    doSym      = 1'b0;
    stype      = lpx_pkg::STYPE_ACCEPTED;
    symTag     = s.expTag;
    memWe      = 1'b0;
    tsWe       = 1'b0;
    memWd      = '0;
    issueItem  = '0;
    if (s.busy && s.ack2 == s.hsReq)
      n.busy = 1'b0;
    if (popValid && !s.symPend)
    begin
      if (popItem.ctl)
      begin
        if (s.rxMode == lpx_pkg::LPX_RX_PASS)
          n.rxMode = lpx_pkg::LPX_RX_IDLE;
        if (popItem.data[15:0] != ~popItem.data[31:16])
        begin
          n.symError = 1'b1;
          doSym      = 1'b1;
          stype      = lpx_pkg::STYPE_NOT_ACC;
          n.rxMode   = lpx_pkg::LPX_RX_DISCARD;
        end
        else if (popItem.data[31:29] == lpx_pkg::STYPE_ACCEPTED)
        begin
          if (popItem.data[28:26] == s.ackTag && s.outCnt != 3'h0)
          begin
            n.ackTag  = s.ackTag + 3'h1;
            n.outCnt  = s.outCnt - 3'h1;
            n.ackBase = (s.outCnt > 3'h1) ? tagStart[s.ackTag + 3'h1] : s.wrPtr;
          end
        end
        else if (popItem.data[31:29] == lpx_pkg::STYPE_RESTART)
          n.rxMode = lpx_pkg::LPX_RX_IDLE;
        else if (s.outCnt != 3'h0)
        begin
          n.replay = 1'b1;
          n.rdPtr  = tagStart[s.ackTag];
          doSym    = 1'b1;
          stype    = lpx_pkg::STYPE_RESTART;
          symTag   = s.ackTag;
        end
      end
      else if (popItem.start && s.rxMode != lpx_pkg::LPX_RX_DISCARD)
      begin
        doSym    = 1'b1;
        n.rxMode = lpx_pkg::LPX_RX_DISCARD;
        if (popItem.data[lpx_pkg::PKT_TAG_HI:lpx_pkg::PKT_TAG_LO] != s.expTag)
          stype = lpx_pkg::STYPE_NOT_ACC;
        else if (!rxReady)
          stype = lpx_pkg::STYPE_RETRY;
        else
        begin
          n.expTag  = s.expTag + 3'h1;
          n.rxMode  = lpx_pkg::LPX_RX_PASS;
          n.rxValid = 1'b1;
          n.rxStart = 1'b1;
          n.rxData  = popItem.data;
        end
      end
      else if (!popItem.start && s.rxMode == lpx_pkg::LPX_RX_PASS)
      begin
        n.rxValid = 1'b1;
        n.rxData  = popItem.data;
      end
    end
    if (doSym)
    begin
      n.symPend = 1'b1;
      // Acknowledges and errors leave only as symbols; there is no sideband pin.
      n.sym = {stype, symTag, lpx_pkg::BUF_STATUS_RETRY, lpx_pkg::SYM_RSV_ZERO};
    end
    // Pending symbols go before replay and new words; a word taken in the cycle a symbol is raised still leaves ahead of it.
    if (!s.busy)
    begin
      if (s.symPend)
      begin
        n.symPend = 1'b0;
        issueItem = {1'b1, lpx_pkg::TYPE_SYMBOL, s.sym, ~s.sym};
      end
      else if (s.replay)
      begin
        issueItem = {replayMem[s.rdPtr][32], lpx_pkg::TYPE_PACKET, replayMem[s.rdPtr][31:0]};
        n.rdPtr   = s.rdPtr + 1'b1;
        if (n.rdPtr == s.wrPtr)
          n.replay = 1'b0;
      end
      else if (accept)
      begin
        memWd = {txStart, txData};
        if (txLast && txHalf)
          memWd[15:0] = 16'h0000;
        if (txStart)
        begin
          memWd[lpx_pkg::PKT_TAG_HI:lpx_pkg::PKT_TAG_LO] = s.sendTag;
          memWd[lpx_pkg::PKT_RSV_HI:lpx_pkg::PKT_RSV_LO] = 3'h0;
          tsWe      = 1'b1;
          n.sendTag = s.sendTag + 3'h1;
          n.outCnt  = n.outCnt + 3'h1;
        end
        memWe     = 1'b1;
        n.wrPtr   = s.wrPtr + 1'b1;
        n.inPkt   = !txLast;
        issueItem = {memWd[32], lpx_pkg::TYPE_PACKET, memWd[31:0]};
      end
      if (s.symPend || s.replay || accept)
      begin
        n.hsItem = issueItem;
        n.hsReq  = !s.hsReq;
        n.busy   = 1'b1;
      end
    end
    // A new packet may only start below the outstanding limit and with replay room.
    n.txReady = !n.busy && !n.symPend && !n.replay && (n.wrPtr + 1'b1 != n.ackBase)
              && (n.inPkt || n.outCnt < lpx_pkg::MAX_OUTSTANDING);
  end

  always_ff @(posedge mclk)
  begin
    s <= rstn ? n : '0;
    if (memWe)
      replayMem[s.wrPtr] <= memWd;
    if (tsWe)
      tagStart[s.sendTag] <= s.wrPtr;
  end

  // Link domain: beat serialiser and deserialiser. The core holds hsItem stable
  // until the toggle comes back, so only the toggle needs synchronising.
  always_comb
  begin
    ln      = l;
    ln.rst1 = rstn;
    ln.rst2 = l.rst1;
    ln.nar1 = narrowMode;
    ln.nar2 = l.nar1;
    ln.req1 = s.hsReq;
    ln.req2 = l.req1;
    ln.rd1  = lnkRxData;
    ln.rd2  = l.rd1;
    ln.rv1  = lnkRxValid;
    ln.rv2  = l.rv1;
    ln.rf1  = lnkRxFrame;
    ln.rf2  = l.rf1;
    ln.rc1  = lnkRxCtl;
    ln.rc2  = l.rc1;
    ln.txData  = 16'h0000;
    ln.txValid = 1'b0;
    ln.txFrame = 1'b0;
    ln.txCtl   = 1'b0;
    beats      = l.nar2 ? lpx_pkg::BEATS_NARROW : lpx_pkg::BEATS_WIDE;
    pushValid  = 1'b0;
    pushItem   = '0;
    nextCnt    = '0;
    if (l.tLeft != 3'h0)
    begin
      ln.txValid = 1'b1;
      ln.txCtl   = l.tCtl;
      ln.txFrame = l.tFirst && l.tStart;
      ln.tFirst  = 1'b0;
      ln.tLeft   = l.tLeft - 3'h1;
      if (l.nar2)
      begin
        ln.txData = {8'h00, l.tShift[31:24]};
        ln.tShift = {l.tShift[23:0], 8'h00};
      end
      else
      begin
        ln.txData = l.tShift[31:16];
        ln.tShift = {l.tShift[15:0], 16'h0000};
      end
    end
    else if (l.req2 != l.reqSeen)
    begin
      ln.reqSeen = l.req2;
      ln.tShift  = s.hsItem.data;
      ln.tCtl    = s.hsItem.ctl;
      ln.tStart  = s.hsItem.start;
      ln.tFirst  = 1'b1;
      ln.tLeft   = beats;
    end
    if (l.rv2)
    begin
      nextCnt   = (l.rf2 ? 3'h0 : l.rCnt) + 3'h1;
      ln.rStart = l.rf2 || l.rStart;
      ln.rCnt   = nextCnt;
      ln.rShift = l.nar2 ? {l.rShift[23:0], l.rd2[7:0]} : {l.rShift[15:0], l.rd2};
      if (nextCnt == beats)
      begin
        // A word that finds the buffer full is dropped; the tag check then refuses it.
        pushValid = 1'b1;
        pushItem  = {ln.rStart, l.rc2, ln.rShift};
        ln.rCnt   = 3'h0;
        ln.rStart = 1'b0;
      end
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (l.rst2)
      l <= ln;
    else
    begin
      l      <= '0;
      l.rst1 <= ln.rst1;
      l.rst2 <= ln.rst2;
    end
  end

  sequence s_symQueued;
    !s.busy && s.symPend;
  endsequence
  sequence s_symIssued;
    s.busy && s.hsItem.ctl;
  endsequence

  property p_outMax;
    @(posedge mclk) disable iff (!rstn) (s.outCnt == lpx_pkg::MAX_OUTSTANDING) |=> s.outCnt != 3'h0;
  endproperty
  a_outMax: assert property (p_outMax) else $error("Too many outstanding packets.");
  property p_noStartAtLimit;
    @(posedge mclk) disable iff (!rstn) (accept && txStart) |-> s.outCnt < 3'h7;
  endproperty
  a_noStartAtLimit: assert property (p_noStartAtLimit) else $error("Start at limit.");
  property p_tagStep;
    @(posedge mclk) disable iff (!rstn)
      (accept && txStart) |=> s.hsItem.data[30:28] == $past(s.sendTag)
                              && s.sendTag == $past(s.sendTag) + 3'h1;
  endproperty
  a_tagStep: assert property (p_tagStep) else $error("Tag not stamped in order.");
  property p_symComplement;
    @(posedge mclk) disable iff (!rstn) s_symQueued |=> s_symIssued
      ##0 (s.hsItem.data[15:0] == ~s.hsItem.data[31:16]);
  endproperty
  a_symComplement: assert property (p_symComplement) else $error("Bad symbol form.");
  property p_pad;
    @(posedge mclk) disable iff (!rstn)
      (accept && txLast && txHalf) |=> s.hsItem.data[15:0] == 16'h0000;
  endproperty
  a_pad: assert property (p_pad) else $error("Short packet not padded.");
  property p_rsvZero;
    @(posedge mclk) disable iff (!rstn) (accept && txStart) |=> s.hsItem.data[27:25] == 3'h0;
  endproperty
  a_rsvZero: assert property (p_rsvZero) else $error("Reserved bits not zero.");
  property p_ackFirst;
    @(posedge mclk) disable iff (!rstn)
      (s.rxStart) |-> s.symPend || (s.busy && s.hsItem.ctl);
  endproperty
  a_ackFirst: assert property (p_ackFirst) else $error("Packet without acknowledge.");
  property p_badSym;
    @(posedge mclk) disable iff (!rstn)
      (popValid && popReady && popItem.ctl && popItem.data[15:0] != ~popItem.data[31:16])
      |=> s.symError && s.symPend && s.sym[15:13] == lpx_pkg::STYPE_NOT_ACC;
  endproperty
  a_badSym: assert property (p_badSym) else $error("Symbol error missed.");
  property p_wrongTag;
    @(posedge mclk) disable iff (!rstn)
      (popValid && popReady && !popItem.ctl && popItem.start && popItem.data[30:28] != s.expTag)
      |=> !s.rxValid && s.expTag == $past(s.expTag);
  endproperty
  a_wrongTag: assert property (p_wrongTag) else $error("Out of order packet taken.");
  property p_narrow;
    @(posedge linkClk) disable iff (!l.rst2) (l.txValid && l.nar2) |-> l.txData[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("Upper lane driven when narrow.");
endmodule // lpx_link_exchange

// [tb/lpx_partner.sv]
// Far-side port model: gathers the words the block sends and replays queued words.
// Assumes the bench runs linkClk, sets the width strap and fills txq.
`timescale 1ns/10ps

module lpx_partner (
  // Link clock and controls
  input  wire logic        linkClk,
  input  wire logic        narrow,
  input  wire logic        autoAck,
  // Pins from the block
  input  wire logic [15:0] lnkTxData,
  input  wire logic        lnkTxValid,
  input  wire logic        lnkTxFrame,
  input  wire logic        lnkTxCtl,
  // Pins to the block
  output logic      [15:0] lnkRxData,
  output logic             lnkRxValid,
  output logic             lnkRxFrame,
  output logic             lnkRxCtl
);
  lpx_pkg::lpx_item_s txq[$];
  lpx_pkg::lpx_item_s got[$];
  lpx_pkg::lpx_item_s cur;
  logic [2:0]         tg;
  int                 beats = 0;
  int                 hiBad = 0;

  function automatic lpx_pkg::lpx_item_s mk_sym(logic [2:0] st, logic [2:0] tag);
    logic [15:0] s;
    s = {st, tag, lpx_pkg::BUF_STATUS_RETRY, lpx_pkg::SYM_RSV_ZERO};
    return {2'b11, s, ~s};
  endfunction

  // Separate receive and transmit paths keep the link full duplex.
  always @(posedge linkClk)
  begin
    if (lnkTxValid === 1'b1)
    begin
      if (lnkTxFrame === 1'b1 || beats == 0)
      begin
        cur.start = lnkTxFrame;
        cur.ctl   = lnkTxCtl;
        beats     = 0;
      end
      cur.data = narrow ? {cur.data[23:0], lnkTxData[7:0]} : {cur.data[15:0], lnkTxData};
      if (narrow && lnkTxData[15:8] !== 8'h00)
        hiBad++;
      beats++;
      if (beats == (narrow ? 4 : 2))
      begin
        got.push_back(cur);
        beats = 0;
        tg    = cur.data[lpx_pkg::PKT_TAG_HI:lpx_pkg::PKT_TAG_LO];
        if (autoAck && cur.start && !cur.ctl)
          txq.push_back(mk_sym(lpx_pkg::STYPE_ACCEPTED, tg));
      end
    end
  end

  task automatic send(input lpx_pkg::lpx_item_s it);
    for (int i = 0; i < (narrow ? 4 : 2); i++)
    begin
      if (i > 0)
      begin
        @(posedge linkClk);
        #1;
      end
      lnkRxValid = 1'b1;
      lnkRxFrame = (i == 0) && it.start;
      lnkRxCtl   = it.ctl;
      lnkRxData  = narrow ? {~it.data[31:24], it.data[31:24]} : it.data[31:16];
      it.data    = narrow ? it.data << 8 : it.data << 16;
    end
  endtask

  initial
  begin
    lnkRxData  = 16'h0000;
    lnkRxValid = 1'b0;
    lnkRxFrame = 1'b0;
    lnkRxCtl   = 1'b0;
    forever
    begin
      @(posedge linkClk);
      #1;
      if (txq.size() == 0)
      begin
        // Idle data lines toggle so that a stale value never passes for data.
        lnkRxValid = 1'b0;
        lnkRxFrame = 1'b0;
        lnkRxData  = ~lnkRxData;
      end
      else
        send(txq.pop_front());
    end
  end
endmodule // lpx_partner

// [tb/lpx_link_exchange_tb_top.sv]
// Self-checking bench of the link packet exchange block against the port model.
// Assumes inputs change on the falling mclk edge and the model owns the link pins.
`timescale 1ns/10ps

module lpx_link_exchange_tb_top;
  typedef struct packed {logic [31:0] d; logic s; logic l; logic h;} lpx_row_s;
  logic        mclk, linkClk, rstn, narrowMode, autoAck, rxReady;
  logic        txValid, txStart, txLast, txHalf, txReady;
  logic        rxValid, rxStart, symError;
  logic [31:0] txData, rxData;
  logic [2:0]  outstanding, txTag;
  logic [15:0] lnkTxData, lnkRxData, h16;
  logic        lnkTxValid, lnkTxFrame, lnkTxCtl, lnkRxValid, lnkRxFrame, lnkRxCtl;
  logic [33:0] r;
  logic [33:0] rxq[$];
  int          failures = 0;
  int          checked = 0;
  int          symErrs = 0;
  int          n;
  lpx_row_s    rows[5] = '{'{32'hA5FF_1234, 1'b1, 1'b0, 1'b0}, '{32'h1357_9BDF, 1'b0, 1'b1, 1'b1},
                           '{32'hFFFF_FFFF, 1'b1, 1'b1, 1'b0}, '{32'h0000_0001, 1'b1, 1'b0, 1'b0},
                           '{32'h8000_0000, 1'b0, 1'b1, 1'b0}};

  lpx_link_exchange u_dut (.mclk, .rstn, .linkClk, .narrowMode, .txValid, .txData, .txStart,
    .txLast, .txHalf, .txReady, .rxValid, .rxData, .rxStart, .rxReady, .outstanding,
    .symError, .lnkTxData, .lnkTxValid, .lnkTxFrame, .lnkTxCtl, .lnkRxData, .lnkRxValid,
    .lnkRxFrame, .lnkRxCtl);
  lpx_partner u_far (.linkClk, .narrow(narrowMode), .autoAck, .lnkTxData, .lnkTxValid,
    .lnkTxFrame, .lnkTxCtl, .lnkRxData, .lnkRxValid, .lnkRxFrame, .lnkRxCtl);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    linkClk = 1'b0;
    #3.3;
    forever #7.5 linkClk = ~linkClk;
  end
  always @(negedge mclk)
  begin
    if (rxValid === 1'b1)
      rxq.push_back({rxStart, 1'b0, rxData});
    if (symError === 1'b1)
      symErrs++;
  end

  task automatic end_of_test();
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [33:0] tx_exp(logic [31:0] d, logic s, logic h, logic [2:0] tag);
    if (h)
      d[15:0] = 16'h0000;
    if (s)
      d[30:25] = {tag, 3'b000};
    return {s, 1'b0, d};
  endfunction

  function automatic logic [33:0] sym_exp(logic [2:0] st, logic [2:0] tag);
    logic [15:0] s;
    s = {st, tag, 4'hF, 6'h00};
    return {2'b11, s, ~s};
  endfunction

  task automatic pop_item(output logic [33:0] q);
    for (int i = 0; i < 300 && u_far.got.size() == 0; i++)
      @(negedge mclk);
    q = (u_far.got.size() > 0) ? u_far.got.pop_front() : '1;
  endtask

  task automatic pop_rx(output logic [33:0] q);
    for (int i = 0; i < 300 && rxq.size() == 0; i++)
      @(negedge mclk);
    q = (rxq.size() > 0) ? rxq.pop_front() : '1;
  endtask

  // The word is held until txReady is seen high ahead of the taking edge.
  task automatic send_word(input logic [31:0] d, input logic s, input logic l, input logic h);
    @(negedge mclk);
    {txValid, txData, txStart, txLast, txHalf} = {1'b1, d, s, l, h};
    for (int i = 0; i < 400 && txReady !== 1'b1; i++)
      @(negedge mclk);
    @(negedge mclk);
    txValid = 1'b0;
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (16) @(negedge mclk);
    chk({28'h0, txReady, rxValid, lnkTxValid, outstanding}, 34'h0);
    rstn = 1'b1;
  endtask

  task automatic rx_try(input logic [2:0] tag, input logic [2:0] st, input logic [2:0] et);
    logic [33:0] q;
    u_far.txq.push_back({3'b100, tag, 28'h0ABC_DEF});
    u_far.txq.push_back({2'b00, 32'h1122_3344});
    pop_item(q);
    chk(q, sym_exp(st, et));
    if (st == lpx_pkg::STYPE_ACCEPTED)
    begin
      pop_rx(q);
      chk(q, {3'b100, tag, 28'h0ABC_DEF});
      pop_rx(q);
      chk(q, {2'b00, 32'h1122_3344});
    end
    else
    begin
      u_far.txq.push_back(u_far.mk_sym(lpx_pkg::STYPE_RESTART, et));
      repeat (40) @(negedge mclk);
      chk(rxq.size(), 0);
    end
  endtask

  initial
  begin
    {narrowMode, txValid, txData, txStart, txLast, txHalf, txTag} = '0;
    {autoAck, rxReady} = 2'b11;
    do_reset();
    foreach (rows[i])
    begin
      send_word(rows[i].d, rows[i].s, rows[i].l, rows[i].h);
      pop_item(r);
      chk(r, tx_exp(rows[i].d, rows[i].s, rows[i].h, txTag));
      txTag = txTag + {2'b00, rows[i].l};
    end
    repeat (60) @(negedge mclk);
    chk(outstanding, 3'h0);
    autoAck = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      send_word(32'h0123_4500 + i, 1'b1, 1'b1, 1'b0);
      pop_item(r);
      chk(r, tx_exp(32'h0123_4500 + i, 1'b1, 1'b0, txTag + i[2:0]));
    end
    repeat (20) @(negedge mclk);
    chk(outstanding, 3'h7);
    {txValid, txStart, txLast, txData} = {3'b111, 32'h0BAD_0000};
    n = 0;
    repeat (40)
    begin
      @(negedge mclk);
      n = n + (txReady === 1'b1);
    end
    txValid = 1'b0;
    chk(n, 0);
    u_far.txq.push_back(u_far.mk_sym(lpx_pkg::STYPE_RETRY, txTag));
    pop_item(r);
    h16 = ~r[31:16];
    chk(r[33:29], 5'h1B);
    chk(r[15:0], h16);
    for (int i = 0; i < 7; i++)
    begin
      pop_item(r);
      chk(r, tx_exp(32'h0123_4500 + i, 1'b1, 1'b0, txTag + i[2:0]));
      u_far.txq.push_back(u_far.mk_sym(lpx_pkg::STYPE_ACCEPTED, txTag + i[2:0]));
    end
    repeat (60) @(negedge mclk);
    chk(outstanding, 3'h0);
    autoAck = 1'b1;
    rx_try(3'h0, 3'h0, 3'h0);
    rx_try(3'h5, 3'h2, 3'h1);
    rx_try(3'h1, 3'h0, 3'h1);
    rxReady = 1'b0;
    rx_try(3'h2, 3'h1, 3'h2);
    rxReady = 1'b1;
    rx_try(3'h2, 3'h0, 3'h2);
    u_far.txq.push_back({2'b11, 32'h1234_1234});
    pop_item(r);
    chk(r, sym_exp(3'h2, 3'h3));
    u_far.txq.push_back(u_far.mk_sym(lpx_pkg::STYPE_RESTART, 3'h3));
    rx_try(3'h3, 3'h0, 3'h3);
    chk(symErrs, 1);
    narrowMode = 1'b1;
    do_reset();
    u_far.got.delete();
    rxq.delete();
    send_word(32'hFEDC_BA98, 1'b1, 1'b1, 1'b0);
    pop_item(r);
    chk(r, tx_exp(32'hFEDC_BA98, 1'b1, 1'b0, 3'h0));
    rx_try(3'h0, 3'h0, 3'h0);
    chk(u_far.hiBad, 0);
    end_of_test();
  end

  // Whole run needs well under 20,000 core cycles; this span is twice that.
  initial
  begin
    #2000000;
    failures++;
    end_of_test();
  end
endmodule // lpx_link_exchange_tb_top
